//--- src/brwcw_pkg.sv
// shared constants and types for the bus register write and command word block
package brwcw_pkg;
   // function codes handled, broadcast address and preset count limit
   localparam logic [7:0] FN_PRESET_ONE = 8'h06;
   localparam logic [7:0] FN_PRESET_MANY = 8'h10;
   localparam logic [7:0] BCAST_ADDR = 8'h00;
   localparam logic [15:0] MAX_PRESET_CNT = 16'h007B;
   // byte counters and command word reset value
   localparam logic [2:0] CNT_ONE = 3'h1;
   localparam logic [2:0] HDR_LAST = 3'h3;
   localparam logic [2:0] RESP_LAST = 3'h5;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   // command word bit positions
   localparam int CW_REF_LO = 0;
   localparam int CW_REF_HI = 1;
   localparam int CW_DC_BRAKE_N = 2;
   localparam int CW_COAST_N = 3;
   localparam int CW_QSTOP_N = 4;
   localparam int CW_FREEZE_N = 5;
   localparam int CW_START = 6;
   localparam int CW_RESET = 7;
   localparam int CW_JOG = 8;
   localparam int CW_RAMP2 = 9;
   localparam int CW_VALID = 10;
   localparam int CW_RELAY1 = 11;
   localparam int CW_RELAY2 = 12;
   localparam int CW_SETUP_LO = 13;
   localparam int CW_SETUP_HI = 14;
   localparam int CW_REVERSE = 15;
   // source select codes
   localparam logic [1:0] SRC_DIGITAL = 2'h0;
   localparam logic [1:0] SRC_BUS = 2'h1;
   localparam logic [1:0] SRC_AND = 2'h2;
   localparam logic [1:0] SRC_OR = 2'h3;
   typedef enum logic [6:0] {
      ST_ADDR = 7'h01,
      ST_FUNC = 7'h02,
      ST_HDR = 7'h04,
      ST_BCNT = 7'h08,
      ST_DATA = 7'h10,
      ST_RESP = 7'h20,
      ST_SKIP = 7'h40
   } brwcw_state_e;
   typedef struct packed {
      logic [1:0] ref_sel;
      logic dc_brake;
      logic coast;
      logic quick_stop;
      logic freeze;
      logic run;
      logic ramp_stop;
      logic trip_reset;
      logic jog;
      logic ramp2_sel;
      logic relay1;
      logic relay2;
      logic [1:0] setup_sel;
      logic reverse;
   } brwcw_act_s;
endpackage

//--- src/brwcw_cmd_if.sv
// command word hand-off between the frame engine and the decoder
`timescale 1ns/1ps
interface brwcw_cmd_if;
   logic wr;
   logic [15:0] word;
   modport src(output wr, output word);
   modport dst(input wr, input word);
endinterface

//--- src/brwcw_decode.sv
// drive command word capture and action decoder
`timescale 1ns/1ps
module brwcw_decode
   import brwcw_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // command word from the frame engine
   brwcw_cmd_if.dst cmd,
   // source selects and settings
   input wire logic [1:0] i_src_coast,
   input wire logic [1:0] i_src_start,
   input wire logic [1:0] i_src_ref,
   input wire logic [1:0] i_src_setup,
   input wire logic [1:0] i_src_reverse,
   input wire logic i_relay1_assigned,
   input wire logic i_relay2_assigned,
   input wire logic i_multi_setup,
   // digital inputs
   input wire logic i_di_coast,
   input wire logic i_di_start,
   input wire logic [1:0] i_di_ref,
   input wire logic [1:0] i_di_setup,
   input wire logic i_di_reverse,
   // decoded actions
   output brwcw_act_s o_act,
   output logic [15:0] o_cmd_word
);
   logic [15:0] word_reg;
   logic [15:0] word_next;
   brwcw_act_s act_reg;
   brwcw_act_s act_next;
   logic take;
   logic coast_req;
   logic start_req;
   logic [1:0] setup_req;

   // bus term and input term joined as the source select asks
   function automatic logic src_comb(input logic [1:0] sel, input logic bus, input logic di);
      case (sel)
         SRC_DIGITAL: src_comb = di;
         SRC_BUS: src_comb = bus;
         SRC_AND: src_comb = bus & di;
         default: src_comb = bus | di;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // next word and actions; all actions move in the same cycle as the word
   always_comb begin
      take = cmd.wr && cmd.word[CW_VALID];
      word_next = take ? cmd.word : word_reg;
      coast_req = src_comb(i_src_coast, !word_next[CW_COAST_N], i_di_coast);
      start_req = src_comb(i_src_start, word_next[CW_START], i_di_start);
      setup_req[0] = src_comb(i_src_setup, word_next[CW_SETUP_LO], i_di_setup[0]);
      setup_req[1] = src_comb(i_src_setup, word_next[CW_SETUP_HI], i_di_setup[1]);
      act_next = act_reg;
      act_next.ref_sel[0] = src_comb(i_src_ref, word_next[CW_REF_LO], i_di_ref[0]);
      act_next.ref_sel[1] = src_comb(i_src_ref, word_next[CW_REF_HI], i_di_ref[1]);
      act_next.dc_brake = !word_next[CW_DC_BRAKE_N];
      act_next.coast = coast_req;
      act_next.freeze = !word_next[CW_FREEZE_N];
      // a frozen output ignores quick and ramp stops; coast and brake still act
      act_next.quick_stop = !word_next[CW_QSTOP_N] && word_next[CW_FREEZE_N];
      act_next.run = start_req && !coast_req;
      act_next.ramp_stop = !start_req && word_next[CW_FREEZE_N];
      act_next.trip_reset = take && cmd.word[CW_RESET] && !word_reg[CW_RESET];
      act_next.jog = word_next[CW_JOG];
      act_next.ramp2_sel = word_next[CW_RAMP2];
      act_next.relay1 = word_next[CW_RELAY1] && i_relay1_assigned;
      act_next.relay2 = word_next[CW_RELAY2] && i_relay2_assigned;
      if (i_multi_setup) begin
         act_next.setup_sel = setup_req;
      end
      act_next.reverse = src_comb(i_src_reverse, word_next[CW_REVERSE], i_di_reverse);
   end

   // registers only
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         word_reg <= CMD_RESET;
         act_reg <= '0;
      end else begin
         word_reg <= word_next;
         act_reg <= act_next;
      end
   end

   assign o_act = act_reg;
   assign o_cmd_word = word_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking dc @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   trip_edge_a: assert property (o_act.trip_reset |-> word_reg[CW_RESET] && !$past(word_reg[CW_RESET])) else $error("trip reset without rising bit");
   invalid_ignored_a: assert property (cmd.wr && !cmd.word[CW_VALID] |=> $stable(word_reg)) else $error("invalid word was used");
   word_capture_a: assert property (cmd.wr && cmd.word[CW_VALID] |=> word_reg == $past(cmd.word) && o_act.jog == $past(cmd.word[CW_JOG])) else $error("word and actions not updated together");
   relay_gate_a: assert property (o_act.relay1 |-> $past(i_relay1_assigned) && word_reg[CW_RELAY1]) else $error("relay one not gated");
   setup_hold_a: assert property (!i_multi_setup |=> $stable(o_act.setup_sel)) else $error("set-up moved in single set-up");
   reverse_src_a: assert property (i_src_reverse == SRC_DIGITAL |=> o_act.reverse == $past(i_di_reverse)) else $error("bus reversed under digital source");
   coast_bus_a: assert property (i_src_coast == SRC_BUS |=> o_act.coast == !word_reg[CW_COAST_N]) else $error("coast does not follow bus bit");
   trip_pulse_c: cover property (o_act.trip_reset);
endmodule

//--- src/brwcw_top.sv
// follower frame engine for register presets, holding registers and command word
// Notes on behaviour
// - function 06 writes its 16-bit value into the one addressed holding register
// - bus register addresses are zero-based: register n travels as n minus one
// - single preset reply echoes follower address, function, address and data
// - function 10 writes consecutive registers from start address, count and byte count
// - multi preset reply gives address, function, start address and register count
// - word bits 1..0 pick one of four preset references
// - bit 2 low gives DC braking and stop, high gives normal ramping
// - bit 3 low coasts at once, high lets the motor start
// - bit 4 low ramps down on the quick-stop ramp
// - bit 5 low freezes output; only coast or brake then stop it
// - bit 6 low ramps to stop, high permits start
// - bit 7 clears a trip only on its rising edge
// - bit 8 high runs at the jog speed setting
// - bit 10 low makes the whole word ignored
// - bit 11 drives relay one only when assigned to the bus
// - bit 12 drives relay two only when assigned to the bus
// - bits 14..13 pick one of four parameter set-ups
// - set-up bits act only when multiple set-ups are enabled
// - bit 15 reverses only when the reverse source includes the bus
// - coast, start, reference and set-up bits join inputs per source select
// - register data travel high byte first, then low byte
`timescale 1ns/1ps
module brwcw_top
   import brwcw_pkg::*;
#(
   parameter int REG_DEPTH = 16,
   parameter logic [15:0] REG_BASE = 16'h0000,
   parameter logic [15:0] CMD_ADDR = 16'h0000
)(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // follower address
   input wire logic [7:0] i_node_addr,
   // received frame bytes
   input wire logic i_rx_valid,
   input wire logic i_rx_sof,
   input wire logic [7:0] i_rx_data,
   output logic o_rx_ready,
   // reply bytes
   output logic o_tx_valid,
   output logic o_tx_last,
   output logic [7:0] o_tx_data,
   input wire logic i_tx_ready,
   // holding register read port
   input wire logic [15:0] i_rd_addr,
   output logic [15:0] o_rd_data,
   // source selects and settings
   input wire logic [1:0] i_src_coast,
   input wire logic [1:0] i_src_start,
   input wire logic [1:0] i_src_ref,
   input wire logic [1:0] i_src_setup,
   input wire logic [1:0] i_src_reverse,
   input wire logic i_relay1_assigned,
   input wire logic i_relay2_assigned,
   input wire logic i_multi_setup,
   // digital inputs
   input wire logic i_di_coast,
   input wire logic i_di_start,
   input wire logic [1:0] i_di_ref,
   input wire logic [1:0] i_di_setup,
   input wire logic i_di_reverse,
   // decoded drive actions
   output brwcw_act_s o_act,
   output logic [15:0] o_cmd_word
);
   localparam int IDX_W = $clog2(REG_DEPTH);

   // the index width and the command word slot must fit the map; refused at elaboration
   if (REG_DEPTH < 2 || REG_DEPTH > 256) begin : g_depth_chk
      $error("REG_DEPTH out of range");
   end
   if (CMD_ADDR < REG_BASE || CMD_ADDR - REG_BASE >= 16'(REG_DEPTH)) begin : g_cmd_chk
      $error("CMD_ADDR outside the register map");
   end

   brwcw_state_e st_reg, st_next;
   logic [2:0] cnt_reg, cnt_next;
   logic [7:0] addr_reg, addr_next;
   logic [7:0] func_reg, func_next;
   logic [15:0] ra_reg, ra_next;
   logic [15:0] w2_reg, w2_next;
   logic [7:0] hi_reg, hi_next;
   logic [15:0] widx_reg, widx_next;
   logic [7:0] tx_data_reg, tx_data_next;
   logic [15:0] rd_reg, rd_next;
   logic cmd_wr_reg, cmd_wr_next;
   logic [15:0] cmd_word_reg, cmd_word_next;
   logic rx_take;
   logic wr_en;
   logic [15:0] wr_addr;
   logic [15:0] wr_data;
   logic [15:0] many_cnt;
   logic [15:0] hold_mem [REG_DEPTH];
   brwcw_state_e done_st;

   brwcw_cmd_if cmd_bus();

   // bus address lies inside the holding register window
   function automatic logic in_map(input logic [15:0] a);
      in_map = (a >= REG_BASE) && (a - REG_BASE < 16'(REG_DEPTH));
   endfunction

   // zero-based bus address to array index
   function automatic logic [IDX_W-1:0] to_idx(input logic [15:0] a);
      to_idx = IDX_W'(a - REG_BASE);
   endfunction

   // reply byte n; both presets reply with the same six-byte shape
   function automatic logic [7:0] resp_byte(input logic [2:0] n);
      case (n)
         3'h0: resp_byte = addr_reg;
         3'h1: resp_byte = func_reg;
         3'h2: resp_byte = ra_reg[15:8];
         3'h3: resp_byte = ra_reg[7:0];
         3'h4: resp_byte = w2_reg[15:8];
         default: resp_byte = w2_reg[7:0];
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // frame engine: parse, write, reply
   always_comb begin
      // no new request is taken while a reply is still going out
      rx_take = i_rx_valid && (st_reg != ST_RESP);
      st_next = st_reg;
      cnt_next = cnt_reg;
      addr_next = addr_reg;
      func_next = func_reg;
      ra_next = ra_reg;
      w2_next = w2_reg;
      hi_next = hi_reg;
      widx_next = widx_reg;
      tx_data_next = tx_data_reg;
      wr_en = 1'b0;
      wr_addr = ra_reg;
      wr_data = {hi_reg, i_rx_data};
      many_cnt = {w2_reg[15:8], i_rx_data};
      // broadcasts are written but never answered
      done_st = (addr_reg == BCAST_ADDR) ? ST_ADDR : ST_RESP;
      if (rx_take && i_rx_sof) begin
         // a start of frame restarts the parse in every state except the reply, where no byte is taken
         addr_next = i_rx_data;
         if (i_rx_data == i_node_addr || i_rx_data == BCAST_ADDR) begin
            st_next = ST_FUNC;
         end else begin
            st_next = ST_SKIP;
         end
      end else begin
         case (st_reg)
            ST_FUNC: begin
               if (rx_take) begin
                  func_next = i_rx_data;
                  cnt_next = '0;
                  if (i_rx_data == FN_PRESET_ONE || i_rx_data == FN_PRESET_MANY) begin
                     st_next = ST_HDR;
                  end else begin
                     st_next = ST_SKIP;
                  end
               end
            end
            ST_HDR: begin
               if (rx_take) begin
                  cnt_next = cnt_reg + CNT_ONE;
                  case (cnt_reg)
                     3'h0: ra_next[15:8] = i_rx_data;
                     3'h1: ra_next[7:0] = i_rx_data;
                     3'h2: w2_next[15:8] = i_rx_data;
                     default: begin
                        w2_next[7:0] = i_rx_data;
                        cnt_next = '0;
                        if (func_reg == FN_PRESET_ONE) begin
                           wr_en = in_map(ra_reg);
                           wr_data = {w2_reg[15:8], i_rx_data};
                           st_next = done_st;
                           tx_data_next = addr_reg;
                        end else if (many_cnt != '0 && many_cnt <= MAX_PRESET_CNT) begin
                           st_next = ST_BCNT;
                        end else begin
                           st_next = ST_SKIP;
                        end
                     end
                  endcase
               end
            end
            ST_BCNT: begin
               if (rx_take) begin
                  cnt_next = '0;
                  widx_next = '0;
                  // byte count must match two bytes per register
                  if (i_rx_data == {w2_reg[6:0], 1'b0}) begin
                     st_next = ST_DATA;
                  end else begin
                     st_next = ST_SKIP;
                  end
               end
            end
            ST_DATA: begin
               if (rx_take) begin
                  if (!cnt_reg[0]) begin
                     hi_next = i_rx_data;
                     cnt_next = CNT_ONE;
                  end else begin
                     wr_addr = ra_reg + widx_reg;
                     wr_en = in_map(wr_addr);
                     widx_next = widx_reg + 16'h0001;
                     cnt_next = '0;
                     if (widx_next == w2_reg) begin
                        st_next = done_st;
                        tx_data_next = addr_reg;
                     end
                  end
               end
            end
            ST_RESP: begin
               if (i_tx_ready) begin
                  if (cnt_reg == RESP_LAST) begin
                     st_next = ST_ADDR;
                     cnt_next = '0;
                  end else begin
                     cnt_next = cnt_reg + CNT_ONE;
                     tx_data_next = resp_byte(cnt_next);
                  end
               end
            end
            ST_ADDR, ST_SKIP: begin
               st_next = st_reg;
            end
            default: begin
               st_next = ST_ADDR;
            end
         endcase
      end
   end

   // frame engine registers
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= ST_ADDR;
         cnt_reg <= '0;
         addr_reg <= '0;
         func_reg <= '0;
         ra_reg <= '0;
         w2_reg <= '0;
         hi_reg <= '0;
         widx_reg <= '0;
         tx_data_reg <= '0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         addr_reg <= addr_next;
         func_reg <= func_next;
         ra_reg <= ra_next;
         w2_reg <= w2_next;
         hi_reg <= hi_next;
         widx_reg <= widx_next;
         tx_data_reg <= tx_data_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // holding registers; writes outside the window are dropped but still answered
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < REG_DEPTH; i++) begin
            hold_mem[i] <= '0;
         end
      end else if (wr_en) begin
         hold_mem[to_idx(wr_addr)] <= wr_data;
      end
   end

   // read port and command word hand-off
   always_comb begin
      rd_next = in_map(i_rd_addr) ? hold_mem[to_idx(i_rd_addr)] : '0;
      cmd_wr_next = wr_en && (wr_addr == CMD_ADDR);
      cmd_word_next = cmd_wr_next ? wr_data : cmd_word_reg;
   end

   // read port and hand-off registers
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         rd_reg <= '0;
         cmd_wr_reg <= 1'b0;
         cmd_word_reg <= CMD_RESET;
      end else begin
         rd_reg <= rd_next;
         cmd_wr_reg <= cmd_wr_next;
         cmd_word_reg <= cmd_word_next;
      end
   end

   // outputs
   assign o_rx_ready = (st_reg != ST_RESP);
   assign o_tx_valid = (st_reg == ST_RESP);
   assign o_tx_last = (st_reg == ST_RESP) && (cnt_reg == RESP_LAST);
   assign o_tx_data = tx_data_reg;
   assign o_rd_data = rd_reg;
   assign cmd_bus.wr = cmd_wr_reg;
   assign cmd_bus.word = cmd_word_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // command word decoder
   brwcw_decode brwcw_decode_i (
      .i_mclk(i_mclk), .i_rst(i_rst), .cmd(cmd_bus.dst),
      .i_src_coast(i_src_coast), .i_src_start(i_src_start), .i_src_ref(i_src_ref),
      .i_src_setup(i_src_setup), .i_src_reverse(i_src_reverse),
      .i_relay1_assigned(i_relay1_assigned), .i_relay2_assigned(i_relay2_assigned),
      .i_multi_setup(i_multi_setup), .i_di_coast(i_di_coast), .i_di_start(i_di_start),
      .i_di_ref(i_di_ref), .i_di_setup(i_di_setup), .i_di_reverse(i_di_reverse),
      .o_act(o_act), .o_cmd_word(o_cmd_word)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking dc @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   single_write_a: assert property (st_reg == ST_HDR && rx_take && !i_rx_sof && cnt_reg == HDR_LAST && func_reg == FN_PRESET_ONE && in_map(ra_reg) |-> wr_en && wr_addr == ra_reg && wr_data == {w2_reg[15:8], i_rx_data}) else $error("single preset not written");
   cmd_slot_a: assert property (wr_en && wr_addr == CMD_ADDR |=> cmd_wr_reg && cmd_word_reg == $past(wr_data)) else $error("command slot write lost");
   echo_head_a: assert property (o_tx_valid && cnt_reg == 3'h0 |-> o_tx_data == addr_reg) else $error("reply does not start with address");
   echo_data_a: assert property (o_tx_valid && i_tx_ready && cnt_reg == 3'h3 |=> o_tx_data == w2_reg[15:8]) else $error("reply byte five wrong");
   multi_write_a: assert property (st_reg == ST_DATA && rx_take && !i_rx_sof && cnt_reg[0] && in_map(ra_reg + widx_reg) |-> wr_en && wr_addr == ra_reg + widx_reg) else $error("multi preset address wrong");
   multi_reply_a: assert property (st_reg == ST_DATA && wr_en && widx_next == w2_reg && addr_reg != BCAST_ADDR |=> o_tx_valid && cnt_reg == 3'h0 && o_tx_data == addr_reg && func_reg == FN_PRESET_MANY) else $error("multi preset reply wrong");
   hi_first_a: assert property (st_reg == ST_DATA && rx_take && !i_rx_sof && cnt_reg[0] |-> wr_data == {hi_reg, i_rx_data}) else $error("byte order wrong");
   reply_len_a: assert property (o_tx_last && i_tx_ready |=> !o_tx_valid) else $error("reply longer than six bytes");

   single_reply_c: cover property (o_tx_last && i_tx_ready && func_reg == FN_PRESET_ONE);
   multi_reply_c: cover property (o_tx_last && i_tx_ready && func_reg == FN_PRESET_MANY);
   bcast_write_c: cover property (wr_en && addr_reg == BCAST_ADDR);
endmodule

//--- verification/brwcw_master.sv
// bus master model: sends request bytes and collects the reply
`timescale 1ns/1ps
module brwcw_master (
   // clock
   input wire logic i_mclk,
   // request bytes toward the follower
   output logic o_rx_valid,
   output logic o_rx_sof,
   output logic [7:0] o_rx_data,
   input wire logic i_rx_ready,
   // reply bytes from the follower
   input wire logic i_tx_valid,
   input wire logic i_tx_last,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_ready
);
   logic [7:0] reply_q[$];
   logic slow = 1'b0;
   int last_seen = 0;
   initial begin
      o_rx_valid = 1'b0;
      o_rx_sof = 1'b0;
      o_rx_data = 8'h00;
      o_tx_ready = 1'b1;
   end
   // slow mode drops ready on every other cycle of the reply to prove the follower holds its byte
   always @(negedge i_mclk) o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
   // a reply byte is taken at the rising edge where valid meets ready; last marks its count
   always @(posedge i_mclk) begin
      if (i_tx_valid && o_tx_ready) begin
         reply_q.push_back(i_tx_data);
         if (i_tx_last) last_seen = reply_q.size();
      end
   end
   // bytes go back to back, high byte of each value first, sof on the address
   task automatic send(input logic [7:0] b[$]);
      foreach (b[k]) begin
         @(negedge i_mclk);
         o_rx_valid = 1'b1;
         o_rx_sof = (k == 0);
         o_rx_data = b[k];
      end
      @(negedge i_mclk);
      o_rx_valid = 1'b0;
      o_rx_sof = 1'b0;
      o_rx_data = ~o_rx_data; // released line shows no stale byte
   endtask
endmodule

//--- verification/brwcw_tb_top.sv
// self-checking bench for the register preset and command word block
`timescale 1ns/1ps
module brwcw_tb_top;
   import brwcw_pkg::*;
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
   $display("Error %s expected %h seen %h", nm, exp, got); end end
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_node_addr = 8'h01;
   logic i_rx_valid, i_rx_sof, o_rx_ready, o_tx_valid, o_tx_last, i_tx_ready;
   logic [7:0] i_rx_data, o_tx_data;
   logic [15:0] i_rd_addr = 16'h0000;
   logic [15:0] o_rd_data, o_cmd_word;
   logic [1:0] i_src_coast = SRC_BUS, i_src_start = SRC_BUS, i_src_ref = SRC_BUS;
   logic [1:0] i_src_setup = SRC_BUS, i_src_reverse = SRC_BUS;
   logic i_relay1_assigned = 1'b1, i_relay2_assigned = 1'b1, i_multi_setup = 1'b1;
   logic i_di_coast = 1'b0, i_di_start = 1'b0, i_di_reverse = 1'b0;
   logic [1:0] i_di_ref = 2'h0, i_di_setup = 2'h0;
   brwcw_act_s o_act;
   int errors = 0, check_count = 0, trips = 0, cycles = 0, t0;
   brwcw_top brwcw_top_i (.*);
   brwcw_master brwcw_master_i (.i_mclk(i_mclk), .o_rx_valid(i_rx_valid), .o_rx_sof(i_rx_sof),
      .o_rx_data(i_rx_data), .i_rx_ready(o_rx_ready), .i_tx_valid(o_tx_valid),
      .i_tx_last(o_tx_last), .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready));
   initial forever #12.5 i_mclk = ~i_mclk;
   // trip clear pulses and the hang limit
   always @(posedge i_mclk) if (o_act.trip_reset === 1'b1) trips++;
   always @(posedge i_mclk) if (++cycles == 20000) begin
      errors++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // decode expected with every source on the bus, relays assigned, multi set-up
   function automatic logic [15:0] act_of(input logic [15:0] w);
      return {w[1:0], ~w[2], ~w[3], ~w[4] & w[5], ~w[5], w[6] & w[3], ~w[6] & w[5], 1'b0,
         w[8], w[9], w[11], w[12], w[14:13], w[15]};
   endfunction
   // send one request, wait a bounded time for n reply bytes, compare the leading n
   task automatic echo(input logic [7:0] q[$], input int n);
      int t;
      brwcw_master_i.reply_q = {};
      brwcw_master_i.last_seen = 0;
      brwcw_master_i.send(q);
      // a frame that is answered stops the receiver for the whole reply
      `CHK("rx_ready", (n == 0), o_rx_ready)
      for (t = 0; t < 60 && brwcw_master_i.reply_q.size() < n; t++) @(posedge i_mclk);
      repeat (3) @(posedge i_mclk);
      `CHK("reply_len", n, brwcw_master_i.reply_q.size())
      `CHK("tx_last", n, brwcw_master_i.last_seen)
      for (t = 0; t < n; t++) `CHK("reply_byte", q[t], brwcw_master_i.reply_q[t])
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(negedge i_mclk);
      i_rd_addr = a;
      @(negedge i_mclk);
      `CHK("holding_reg", exp, o_rd_data)
   endtask
   // command word goes to bus address 0 by a single preset
   task automatic cmd(input logic [15:0] w, input logic [15:0] exp_w);
      echo({8'h01, 8'h06, 8'h00, 8'h00, w[15:8], w[7:0]}, 6);
      `CHK("cmd_word", exp_w, o_cmd_word)
      `CHK("act", act_of(exp_w), 16'(o_act))
   endtask
   task automatic close_out();
      $display("errors %0d comparisons %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // single preset with a stalling reader, register 4 travels as 3
   task automatic single_preset();
      brwcw_master_i.slow = 1'b1;
      echo({8'h01, 8'h06, 8'h00, 8'h03, 8'h06, 8'h07}, 6);
      brwcw_master_i.slow = 1'b0;
      rd(16'h0003, 16'h0607);
   endtask
   // multi preset of two registers, reply is the six header bytes
   task automatic multi_preset();
      echo({8'h01, 8'h10, 8'h00, 8'h04, 8'h00, 8'h02, 8'h04, 8'h00, 8'h16, 8'h02, 8'hE2}, 6);
      rd(16'h0004, 16'h0016);
      rd(16'h0005, 16'h02E2);
   endtask
   // request for another follower is neither written nor answered
   task automatic foreign_frame();
      echo({8'h02, 8'h06, 8'h00, 8'h06, 8'h12, 8'h34}, 0);
      rd(16'h0006, 16'h0000);
   endtask
   // reset in mid-run clears the stored word, the actions and the registers
   task automatic mid_reset();
      @(negedge i_mclk);
      i_rst = 1'b1;
      @(negedge i_mclk);
      `CHK("rst_word", CMD_RESET, o_cmd_word)
      `CHK("rst_act", 16'h0000, 16'(o_act))
      `CHK("rst_tx_valid", 1'b0, o_tx_valid)
      i_rst = 1'b0;
      rd(16'h0003, 16'h0000);
   endtask
   initial begin
      repeat (6) @(posedge i_mclk);
      @(negedge i_mclk);
      i_rst = 1'b0;
      single_preset();
      multi_preset();
      foreign_frame();
      command_words();
      source_gating();
      mid_reset();
      close_out();
   end
   // command words: reset clears only on a rising bit 7
   task automatic command_words();
      cmd(16'h0400, 16'h0400);
      t0 = trips;
      cmd(16'hFFFF, 16'hFFFF);
      `CHK("trip_pulse", t0 + 1, trips)
      cmd(16'hFFFF, 16'hFFFF);
      `CHK("trip_steady", t0 + 1, trips)
      cmd(16'h8D6A, 16'h8D6A);
      cmd(16'h3B7F, 16'h8D6A);
   endtask
   // gating by assignment and source selects
   task automatic source_gating();
      @(negedge i_mclk);
      i_relay1_assigned = 1'b0;
      i_src_reverse = SRC_DIGITAL;
      i_src_coast = SRC_OR;
      i_di_coast = 1'b1;
      i_multi_setup = 1'b0;
      repeat (3) @(negedge i_mclk);
      `CHK("relay1", 1'b0, o_act.relay1)
      `CHK("reverse", 1'b0, o_act.reverse)
      `CHK("coast", 1'b1, o_act.coast)
      `CHK("run", 1'b0, o_act.run)
      echo({8'h01, 8'h06, 8'h00, 8'h00, 8'h64, 8'h00}, 6);
      `CHK("setup_held", 2'h0, o_act.setup_sel)
   endtask
endmodule
